// ==== core/sacc_ctrl.sv ====
// Conversion and calibration sequencer of a successive-approximation converter.
// Assumes all control pins are asynchronous to clk_sys; all but rst are synchronised here.
`timescale 1ns/1ps

// How it works
// RULE_01: Host keeps calibration request and interleave levels valid while selecting.
// RULE_02: Host allows six clocks plus 2.25 us acquisition between conversions.
// RULE_03: Conversion runs on clock/4; an unaligned hold waits up to four clocks.
// RULE_04: A conversion lasts at least 57 master clocks.
// RULE_05: Track-done falls exactly 15 clocks after conversion-done falls.
// RULE_06: Track-done looped to hold gives 57-clock conversions, 72-clock throughput.
// RULE_07: External logic may count clocks after conversion-done to issue hold.
// RULE_08: Reset beats everything, aborts activity and starts a new calibration.
// RULE_09: Reset pin clears logic; release starts a 1,443,840-clock calibration.
// RULE_10: Select, low address bit and hold all low give a software reset.
// RULE_11: Conversion-done stays high during reset calibration and falls at its end.
// RULE_12: Host waits six clocks plus 2.25 us after reset calibration ends.
// RULE_13: In stand-alone wiring conversion-done does not fall after reset calibration.
// RULE_14: Burst calibration loops while request is high, latched at select release.
// RULE_15: Burst calibration resumes where earlier burst or interleave stopped.
// RULE_16: Host waits 26 clocks plus 2.25 us after dropping the calibration request.
// RULE_17: Conversion-done marks the last experiment after a burst ends.
// RULE_18: Interleave appends one experiment, adding 20 clocks to each conversion.
// RULE_19: Transfer function updates only after the full 72,192-experiment sequence.
// RULE_20: Burst calibration has priority over interleave.
// RULE_21: A sampled falling hold edge starts a conversion.
// RULE_22: Conversion-done returns high within four clocks of a read or a new start.
// RULE_23: All durations are cycle counters; hold is synchronised before use.
module sacc_ctrl
  import sacc_pkg::*;
#(
  parameter int RCAL_CYCLES = sacc_pkg::RCAL_CYC,
  parameter int EXPER_COUNT = sacc_pkg::EXPER_NUM
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hold_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic low_address_bit,
  input wire logic cal_req,
  input wire logic interleave_enable_n,
  output logic conv_done_n,
  output logic track_done_n,
  output logic converting,
  output logic calibrating,
  output logic tracking,
  output logic acq_ready,
  output logic cal_update
);
  import sacc_pkg::*;

  localparam logic [CNT_W-1:0] RCAL_LAST = CNT_W'(RCAL_CYCLES - 1);
  localparam logic [EXP_W-1:0] EXP_LAST = EXP_W'(EXPER_COUNT - 1);
  localparam logic [CNT_W-1:0] EXP_CYC_LAST = CNT_W'(EXPER_CYC - 1);
  localparam logic [CNT_W-1:0] CONV_PLAIN_LAST = CNT_W'(CONV_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] CONV_ILV_LAST = CNT_W'(CONV_MIN_CYC + ILV_EXTRA_CYC - 1);
  localparam logic [CNT_W-1:0] CONV_START = CNT_W'(CONV_OFS);
  localparam logic [TRK_W-1:0] TRK_FALL = TRK_W'(TRACK_DONE_CYC - 1);
  localparam logic [TRK_W-1:0] TRK_SAT = TRK_W'(TRACK_DONE_CYC);
  localparam logic [ECNT_W-1:0] ECNT_LAST = ECNT_W'(EOC_READ_CYC - 1);
  localparam logic [ACQ_W-1:0] ACQ_LOAD = ACQ_W'(ACQ_CYC);

  // Advance the shared experiment pointer; top bit flags a finished sequence
  function automatic logic [EXP_W:0] next_exp(input logic [EXP_W-1:0] idx);
    if (idx == EXP_LAST) begin
      return {1'b1, {EXP_W{1'b0}}};
    end
    return {1'b0, idx + EXP_W'(1)};
  endfunction : next_exp

  logic [SYN_W-1:0] pins;
  logic [SYN_W-1:0] syn;
  sacc_state_s q;
  sacc_state_s d;
  logic s_hold_n;
  logic s_cs_n;
  logic s_rd_n;
  logic s_lab;
  logic hold_fall;
  logic data_rd;
  logic sw_rst;
  logic stand_alone;
  logic [CNT_W-1:0] conv_last;

  assign pins = {interleave_enable_n, cal_req, low_address_bit, rd_n, cs_n, hold_n};

  // Every pin is asynchronous, so all but rst pass two flops first
  sacc_sync #(.W(SYN_W), .RST_VAL(SYN_RST)) u_sync ( // [RULE_23]
    .clk_sys(clk_sys),
    .rst(rst),
    .d(pins),
    .q(syn)
  );

  // Decoded pin conditions
  assign s_hold_n = syn[PIN_HOLD];
  assign s_cs_n = syn[PIN_CS];
  assign s_rd_n = syn[PIN_RD];
  assign s_lab = syn[PIN_LAB];
  assign hold_fall = q.hold_prev && !s_hold_n; // [RULE_21]
  assign data_rd = !s_cs_n && !s_rd_n && s_lab;
  assign sw_rst = !s_cs_n && !s_lab && !s_hold_n; // [RULE_10]
  assign stand_alone = !s_cs_n && !s_rd_n && s_lab;
  assign conv_last = q.ilv ? CONV_ILV_LAST : CONV_PLAIN_LAST; // [RULE_18]

  // Next-state logic of the whole sequencer
  always_comb begin
    d = q;
    d.upd = 1'b0;
    d.div = q.div + 2'h1; // [RULE_03]
    d.hold_prev = s_hold_n;
    // Calibration inputs follow the pins while selected, freeze at release
    if (!s_cs_n) begin // [RULE_14]
      d.cal_lat = syn[PIN_CAL];
      d.ilv_lat_n = syn[PIN_ILV];
    end
    if (q.acq != '0) begin
      d.acq = q.acq - ACQ_W'(1);
    end
    // A data read lets conversion-done go high only after at least four low clocks
    if (!q.eoc_n) begin
      if (q.ecnt != ECNT_LAST) begin
        d.ecnt = q.ecnt + ECNT_W'(1);
      end else if (data_rd) begin
        d.eoc_n = 1'b1; // [RULE_22]
      end
    end
    unique case (q.st)
      ST_RCAL: begin
        if (q.cnt == RCAL_LAST) begin // [RULE_09]
          d.st = ST_TRACK;
          d.cal = 1'b0;
          d.tracking = 1'b1;
          d.expn = '0;
          d.upd = 1'b1;
          d.trk = '0;
          d.acq = ACQ_LOAD;
          d.ecnt = '0;
          d.eoc_n = stand_alone; // [RULE_11] [RULE_13]
        end else begin
          d.cnt = q.cnt + CNT_W'(1);
        end
      end
      ST_TRACK: begin
        if (q.trk != TRK_SAT) begin
          d.trk = q.trk + TRK_W'(1);
        end
        if (q.trk == TRK_FALL) begin
          d.trk_n = 1'b0; // [RULE_05]
        end
        if (hold_fall) begin
          d.pend = 1'b1;
        end
        // Burst wins over a pending sample and over interleave
        if (q.cal_lat) begin // [RULE_20]
          d.st = ST_BURST;
          d.cnt = '0;
          d.cal = 1'b1;
          d.tracking = 1'b0;
          d.pend = 1'b0;
          d.trk_n = 1'b1;
        end else if ((q.pend || hold_fall) && q.div == 2'h0) begin // [RULE_03]
          d.st = ST_CONV;
          d.cnt = CONV_START; // [RULE_06]
          d.conv = 1'b1;
          d.tracking = 1'b0;
          d.pend = 1'b0;
          d.trk_n = 1'b1;
          d.eoc_n = 1'b1; // [RULE_22]
          d.ecnt = '0;
          d.ilv = !q.ilv_lat_n; // [RULE_18]
        end
      end
      ST_CONV: begin
        if (q.cnt == conv_last) begin // [RULE_04]
          d.st = ST_TRACK;
          d.conv = 1'b0;
          d.tracking = 1'b1;
          d.eoc_n = 1'b0;
          d.ecnt = '0;
          d.trk = '0;
          d.acq = ACQ_LOAD;
          if (q.ilv) begin
            {d.upd, d.expn} = next_exp(q.expn); // [RULE_19]
          end
        end else begin
          d.cnt = q.cnt + CNT_W'(1);
        end
      end
      ST_BURST: begin
        // Experiments run to their end unless a reset aborts them, so the pointer stays exact
        if (q.cnt == EXP_CYC_LAST) begin
          {d.upd, d.expn} = next_exp(q.expn); // [RULE_15] [RULE_19]
          d.cnt = '0;
          if (!q.cal_lat) begin // [RULE_14]
            d.st = ST_TRACK;
            d.cal = 1'b0;
            d.tracking = 1'b1;
            d.eoc_n = 1'b0; // [RULE_17]
            d.ecnt = '0;
            d.trk = '0;
            d.acq = ACQ_LOAD;
          end
        end else begin
          d.cnt = q.cnt + CNT_W'(1);
        end
      end
    endcase
    // Software reset overrides everything and restarts full calibration
    if (sw_rst) begin // [RULE_08] [RULE_10]
      d = SACC_RST;
      d.hold_prev = s_hold_n;
    end
    d.acq_rdy = (d.st == ST_TRACK) && (d.acq == '0);
  end

  // Single state register; the pin reset clears everything
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin // [RULE_08] [RULE_09]
      q <= SACC_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign conv_done_n = q.eoc_n;
  assign track_done_n = q.trk_n;
  assign converting = q.conv;
  assign calibrating = q.cal;
  assign tracking = q.tracking;
  assign acq_ready = q.acq_rdy;
  assign cal_update = q.upd;

  // Helper: cycles so far in the current converting stretch, cleared once it ends
  logic [7:0] conv_run_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_run_q <= 8'h00;
    end else if (q.conv) begin
      conv_run_q <= conv_run_q + 8'h01;
    end else begin
      conv_run_q <= 8'h00;
    end
  end

  // Helper: clean tracking cycles since conversion-done fell
  // A counter keeps the track-done property short however long the spacing grows
  logic [4:0] trk_run_q;
  logic cdn_prev_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trk_run_q <= 5'h00;
      cdn_prev_q <= 1'b1;
    end else begin
      cdn_prev_q <= conv_done_n;
      if (cdn_prev_q && !conv_done_n) begin
        trk_run_q <= 5'h01;
      end else if (trk_run_q != 5'h00 && trk_run_q != 5'h1f && tracking && !q.pend
          && !q.cal_lat) begin
        trk_run_q <= trk_run_q + 5'h01;
      end else begin
        trk_run_q <= 5'h00;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_conv_length: assert property ($fell(converting) && !calibrating |-> // [RULE_04]
      conv_run_q == 8'(CONV_MIN_CYC - CONV_OFS) ||
      conv_run_q == 8'(CONV_MIN_CYC + ILV_EXTRA_CYC - CONV_OFS))
    else $error("conversion length wrong");
  a_ilv_length: assert property ($rose(converting) && q.ilv ##1 converting[*3] |-> // [RULE_18]
      ##[70:71] $fell(converting))
    else $error("interleaved conversion length wrong");
  a_start_align: assert property ($rose(converting) |-> q.div == 2'h1) // [RULE_03]
    else $error("conversion not aligned to internal clock");
  a_track_fall: assert property (trk_run_q == 5'(TRACK_DONE_CYC) |-> // [RULE_05]
      $fell(track_done_n))
    else $error("track-done not 15 clocks after conversion-done");
  a_rcal_eoc_high: assert property (q.st == ST_RCAL |-> conv_done_n && calibrating) // [RULE_11]
    else $error("conversion-done low during reset calibration");
  a_swrst_cal: assert property (sw_rst |=> q.st == ST_RCAL && q.cnt == '0 // [RULE_10]
      && conv_done_n && !converting)
    else $error("software reset not taken");
  a_read_release: assert property (!conv_done_n && data_rd && tracking // [RULE_22]
      |-> ##[1:4] conv_done_n)
    else $error("conversion-done not released by read");
  a_burst_prio: assert property (q.st == ST_BURST |-> !converting && calibrating) // [RULE_20]
    else $error("conversion during burst");
  a_burst_end: assert property ($fell(calibrating) && $past(q.st) == ST_BURST // [RULE_17]
      |-> !conv_done_n && $past(q.cnt) == EXP_CYC_LAST)
    else $error("burst end not signalled");
  a_update_wrap: assert property ($rose(cal_update) && $past(q.st) != ST_RCAL // [RULE_19]
      |-> $past(q.expn) == EXP_LAST && q.expn == '0)
    else $error("update without full sequence");
  a_hold_start: assert property (q.st == ST_TRACK && hold_fall && !q.cal_lat && !sw_rst // [RULE_21]
      |-> ##[1:4] converting)
    else $error("hold fall did not start conversion");

  c_conversion: cover property ($fell(converting) && !calibrating);
  c_interleave: cover property ($rose(converting) && q.ilv);
  c_burst_end: cover property ($fell(calibrating) && $past(q.st) == ST_BURST);
  c_sw_reset: cover property (sw_rst && q.st == ST_CONV);

endmodule : sacc_ctrl

// ==== core/sacc_pkg.sv ====
// Constants, state enumeration and state record of the converter sequencer.
// Assumes one 50 MHz master clock; timing figures below count its cycles, except the nanosecond values.
package sacc_pkg;

  // Master clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int DIV_RATIO = 4;              // Internal conversion clock divider

  // Conversion timing in master clocks
  localparam int CONV_MIN_CYC = 57;
  localparam int ILV_EXTRA_CYC = 20;         // One appended calibration experiment
  localparam int EXPER_CYC = 20;             // One burst calibration experiment
  localparam int TRACK_DONE_CYC = 15;        // Conversion-done fall to track-done fall
  localparam int CONV_OFS = 3;               // Hold pin fall to start decision latency
  localparam int EOC_READ_CYC = 4;           // Least conversion-done low clocks before a read can release it

  // Acquisition: six clocks plus 2.25 us, least time rounds up
  localparam int ACQ_BASE_CYC = 6;
  localparam int ACQ_TIME_NS = 2250;
  localparam int ACQ_CYC = ACQ_BASE_CYC + (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Calibration defaults
  localparam int RCAL_CYC = 1443840;         // Full reset calibration
  localparam int EXPER_NUM = 72192;          // Experiments in one full sequence

  // Field widths
  localparam int CNT_W = 21;
  localparam int EXP_W = 17;
  localparam int ACQ_W = 8;
  localparam int TRK_W = 4;
  localparam int ECNT_W = 2;

  // Synchronised pin vector: bit positions and idle values
  localparam int SYN_W = 6;
  localparam int PIN_HOLD = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_RD = 2;
  localparam int PIN_LAB = 3;
  localparam int PIN_CAL = 4;
  localparam int PIN_ILV = 5;
  localparam logic [SYN_W-1:0] SYN_RST = 6'h2f;

  typedef enum logic [1:0] {ST_RCAL, ST_TRACK, ST_CONV, ST_BURST} sacc_state_e;

  typedef struct packed {
    sacc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [TRK_W-1:0] trk;
    logic [ACQ_W-1:0] acq;
    logic [1:0] div;
    logic [EXP_W-1:0] expn;
    logic [ECNT_W-1:0] ecnt;
    logic eoc_n;
    logic trk_n;
    logic conv;
    logic cal;
    logic tracking;
    logic acq_rdy;
    logic upd;
    logic ilv;
    logic pend;
    logic cal_lat;
    logic ilv_lat_n;
    logic hold_prev;
  } sacc_state_s;

  // Cleared state: reset calibration running, conversion-done high
  localparam sacc_state_s SACC_RST = '{
    st: ST_RCAL, cnt: '0, trk: '0, acq: '0, div: '0, expn: '0, ecnt: '0,
    eoc_n: 1'b1, trk_n: 1'b1, conv: 1'b0, cal: 1'b1, tracking: 1'b0,
    acq_rdy: 1'b0, upd: 1'b0, ilv: 1'b0, pend: 1'b0, cal_lat: 1'b0,
    ilv_lat_n: 1'b1, hold_prev: 1'b1};

endpackage : sacc_pkg

// ==== core/sacc_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes the bits are independent levels; no bus coherence is implied.
`timescale 1ns/1ps
module sacc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : sacc_sync

// ==== tb/sacc_host.sv ====
// Host model: strobes hold after acquisition, or loops track-done back.
// Assumes conv_done_n and track_done_n come straight from the sequencer.
`timescale 1ns/1ps
module sacc_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_done_n,
  input wire logic track_done_n,
  input wire logic loop_en,
  input wire logic req,
  output logic hold_n
);
  import sacc_pkg::*;
  logic [7:0] acq_q;
  logic [1:0] low_q;
  logic pend_q;
  logic cdn_q;
  // Acquisition count restarts at each conversion-done fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acq_q <= 8'hff;
      low_q <= 2'h0;
      pend_q <= 1'b0;
      cdn_q <= 1'b1;
    end else begin
      cdn_q <= conv_done_n;
      if (cdn_q && !conv_done_n) acq_q <= 8'h00;
      else if (acq_q != 8'hff) acq_q <= acq_q + 8'h01;
      if (req) pend_q <= 1'b1;
      // A request waits until the input is acquired; early holds would sample badly
      if (low_q != 2'h0) low_q <= low_q - 2'h1;
      else if (pend_q && acq_q > 8'(ACQ_CYC)) begin
        low_q <= 2'h3; // Over one clock, far under 57
        pend_q <= 1'b0;
      end
    end
  end
  // Loopback wiring removes the start uncertainty
  assign hold_n = loop_en ? track_done_n : (low_q == 2'h0);
endmodule : sacc_host

// ==== tb/sacc_ctrl_bench.sv ====
// Self-checking bench of the converter sequencer with a host model.
// Assumes short reset calibration and a four-step experiment sequence.
`timescale 1ns/1ps
module sacc_ctrl_bench;
  import sacc_pkg::*;
  localparam int RCAL = 200;
  localparam int EXPN = 4;
  localparam int W_HOLD = 0;
  localparam int W_CDN = 1;
  localparam int W_TDN = 2;
  localparam int W_CAL = 3;
  localparam int W_CNV = 4;
  localparam int W_ACQ = 5;
  logic clk_sys, rst, cs_n, rd_n, lab, cal_req, ilv_n, loop_en, req, hold_n;
  logic conv_done_n, track_done_n, converting, calibrating, cal_update;
  logic tracking, acq_ready;
  int err_total, checked, cyc, ups, n, a, b;

  // 50 MHz master clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  sacc_host u_host (.clk_sys(clk_sys), .rst(rst), .conv_done_n(conv_done_n),
    .track_done_n(track_done_n), .loop_en(loop_en), .req(req), .hold_n(hold_n));
  sacc_ctrl #(.RCAL_CYCLES(RCAL), .EXPER_COUNT(EXPN)) u_dut (.clk_sys(clk_sys),
    .rst(rst), .hold_n(hold_n), .cs_n(cs_n), .rd_n(rd_n), .low_address_bit(lab),
    .cal_req(cal_req), .interleave_enable_n(ilv_n), .conv_done_n(conv_done_n),
    .track_done_n(track_done_n), .converting(converting), .calibrating(calibrating),
    .tracking(tracking), .acq_ready(acq_ready), .cal_update(cal_update));

  task automatic finish_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Cycle ceiling cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  function automatic logic pick(input int w);
    case (w)
      W_HOLD: return hold_n;
      W_CDN: return conv_done_n;
      W_TDN: return track_done_n;
      W_CAL: return calibrating;
      W_ACQ: return acq_ready;
      default: return converting;
    endcase
  endfunction : pick

  // Count falling edges until an output reaches a level; also tally update pulses
  task automatic wait_for(input int w, input logic v, input int lim, output int c);
    c = 0;
    while (pick(w) !== v && c < lim) begin
      @(negedge clk_sys);
      c++;
      if (cal_update === 1'b1) ups++;
    end
    if (c >= lim) check(1'b0, "wait limit");
  endtask : wait_for

  task automatic clks(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : clks

  // Ask the host for one hold strobe
  task automatic strobe;
    @(posedge clk_sys);
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
    @(negedge clk_sys);
  endtask : strobe

  // Select pulse; the controls stay put afterwards since select latches them
  task automatic sel(input logic cal, input logic iln);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    cal_req <= cal;
    ilv_n <= iln;
    clks(3);
    cs_n <= 1'b1;
  endtask : sel

  task automatic reset_run(input logic sa);
    @(posedge clk_sys);
    rst <= 1'b1;
    cs_n <= !sa;
    rd_n <= !sa;
    clks(10);
    @(negedge clk_sys);
    check(calibrating === 1'b1 && conv_done_n === 1'b1 && converting === 1'b0, "rst");
    check(tracking === 1'b0 && acq_ready === 1'b0, "rst idle");
    @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    wait_for(W_CAL, 1'b0, RCAL + 20, n);
    check(n == RCAL && cal_update === 1'b1, "cal length");
    check(conv_done_n === sa, "cal end");
    @(posedge clk_sys);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask : reset_run

  // Timed conversion, track-done spacing, then a data read
  task automatic conv_once(input int base);
    strobe();
    wait_for(W_HOLD, 1'b0, 400, n);
    wait_for(W_CDN, 1'b1, 20, a);
    wait_for(W_CDN, 1'b0, 150, b);
    check(a + b >= base && a + b <= base + 4, "conv time");
    wait_for(W_TDN, 1'b0, 40, n);
    check(n == TRACK_DONE_CYC && tracking === 1'b1, "track done");
    wait_for(W_ACQ, 1'b1, 150, n);
    check(n == ACQ_CYC - TRACK_DONE_CYC, "acq ready");
    @(posedge clk_sys);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    @(negedge clk_sys);
    wait_for(W_CDN, 1'b1, 20, n);
    check(n <= 6, "read release");
    @(posedge clk_sys);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask : conv_once

  task automatic t_loop;
    @(posedge clk_sys);
    loop_en <= 1'b1;
    @(negedge clk_sys);
    wait_for(W_CDN, 1'b0, 200, n);
    wait_for(W_CDN, 1'b1, 20, a);
    wait_for(W_CDN, 1'b0, 100, b);
    check(a + b == 72, "loop period");
    sel(1'b0, 1'b0);
    @(negedge clk_sys);
    repeat (2) begin
      wait_for(W_CDN, 1'b1, 100, a);
      wait_for(W_CDN, 1'b0, 100, b);
    end
    check(a + b == 72 + ILV_EXTRA_CYC, "ilv period");
    ups = 0;
    repeat (8) begin
      wait_for(W_CDN, 1'b1, 100, a);
      wait_for(W_CDN, 1'b0, 100, b);
    end
    check(ups == 8 / EXPN, "update count");
    @(posedge clk_sys);
    loop_en <= 1'b0;
    sel(1'b0, 1'b1);
    clks(120);
  endtask : t_loop

  task automatic t_burst;
    sel(1'b1, 1'b0);
    @(negedge clk_sys);
    wait_for(W_CAL, 1'b1, 10, n);
    clks(100);
    @(negedge clk_sys);
    check(calibrating === 1'b1 && converting === 1'b0, "burst loop");
    sel(1'b0, 1'b0);
    @(negedge clk_sys);
    wait_for(W_CAL, 1'b0, 40, n);
    check(conv_done_n === 1'b0, "burst end");
    clks(26 + ACQ_CYC - ACQ_BASE_CYC);
    conv_once(CONV_MIN_CYC + ILV_EXTRA_CYC);
    sel(1'b0, 1'b1);
  endtask : t_burst

  task automatic t_soft;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    lab <= 1'b0;
    strobe();
    wait_for(W_CAL, 1'b1, 400, n);
    check(conv_done_n === 1'b1 && converting === 1'b0, "soft reset");
    @(posedge clk_sys);
    cs_n <= 1'b1;
    lab <= 1'b1;
    @(negedge clk_sys);
    wait_for(W_CAL, 1'b0, RCAL + 20, n);
    check(conv_done_n === 1'b0, "soft cal end");
  endtask : t_soft

  // Main sequence
  initial begin
    rst = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    lab = 1'b1;
    cal_req = 1'b0;
    ilv_n = 1'b1;
    loop_en = 1'b0;
    req = 1'b0;
    reset_run(1'b0);
    conv_once(CONV_MIN_CYC);
    t_loop();
    t_burst();
    t_soft();
    strobe();
    wait_for(W_CNV, 1'b1, 400, n);
    clks(10);
    reset_run(1'b0);
    reset_run(1'b1);
    finish_test();
  end
endmodule : sacc_ctrl_bench
